// *** common/odt_pkg.sv ***
package odt_pkg;
   // clock and analog timing, in picoseconds
   localparam int CLK_PS          = 4000;
   localparam int T_AONPD_MIN_PS  = 2000;
   localparam int T_AONPD_MAX_PS  = 8500;
   localparam int T_AOFPD_MIN_PS  = 2000;
   localparam int T_AOFPD_MAX_PS  = 8500;
   localparam int T_RFC_PS        = 260000;
   localparam int T_XPDLL_PS      = 24000;
   // least times round up, longest round down
   localparam int ASYNC_MIN_CYC   = (T_AONPD_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int ASYNC_MAX_CYC   = T_AONPD_MAX_PS / CLK_PS;
   localparam int RFC_CYC         = (T_RFC_PS + CLK_PS - 1) / CLK_PS;
   localparam int XPDLL_CYC       = (T_XPDLL_PS + CLK_PS - 1) / CLK_PS;
   // widths and fixed offsets
   localparam int LAT_W           = 4;
   localparam int ODTL_W          = 6;
   localparam int LINE_DEPTH      = 32;
   localparam int CNT_W           = 8;
   localparam logic [ODTL_W-1:0] ODTL_OFFSET = 6'h02;
   localparam logic [ODTL_W-1:0] ANPD_EXTRA  = 6'h01;
   localparam logic [4:0] ASYNC_TAP  = 5'(ASYNC_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] RFC_LOAD   = CNT_W'(RFC_CYC);
   localparam logic [CNT_W-1:0] XPDLL_LOAD = CNT_W'(XPDLL_CYC);
   localparam logic RTT_RESET = 1'b0;

   typedef enum logic [1:0] {
      ODT_SYNC,
      ODT_ENTRY_WAIT,
      ODT_ASYNC,
      ODT_EXIT_WAIT
   } odt_mode_t;
endpackage

// *** logic/odt_delay_line.sv ***
`timescale 1ns/1ns
module odt_delay_line
   import odt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       odtIn,
   input  wire logic [4:0] syncTap,
   output logic            syncOut,
   output logic            asyncOut
);
   import odt_pkg::*;

   logic [LINE_DEPTH-1:0] line;
   logic [LINE_DEPTH-1:0] next_line;

   always_comb
   begin
      next_line = {line[LINE_DEPTH-2:0], odtIn};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         line <= '0;
      else
         line <= next_line;
   end

   // stage k holds the pin as sampled k+1 edges ago
   assign syncOut  = line[syncTap];
   assign asyncOut = line[ASYNC_TAP];
endmodule // odt_delay_line

// *** logic/odt_powerdown_transition.sv ***
`timescale 1ns/1ns
// How it works
// R1: transition only when DLL-off power-down selected
// R2: entry window tANPD before CKE low edge
// R3: tANPD is write latency minus one
// R4: in-flight refresh stretches entry to tRFC
// R5: rising ODT in entry within mixed bounds
// R6: falling ODT in entry within mixed bounds
// R7: exit window tANPD before plus tXPDLL after
// R8: rising ODT in exit within mixed bounds
// R9: falling ODT in exit within mixed bounds
// R10: before entry synchronous, after it asynchronous
// R11: before exit asynchronous, after it synchronous
// R12: short CKE low merges windows end-to-end
// R13: short CKE high merges windows end-to-end
// R14: sync latencies equal CWL plus AL minus two; code uses a latency of 2 when CWL plus AL is 2 or 3
// R15: controller treats window termination as uncertain
module odt_powerdown_transition
   import odt_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             cke,
   input  wire logic             odtPin,
   input  wire logic             refreshCmd,
   input  wire logic             dllOnInPowerdown,
   input  wire logic [LAT_W-1:0] casWriteLat,
   input  wire logic [LAT_W-1:0] additiveLat,
   output logic                  rttOn,
   output logic                  asyncMode,
   output logic                  transWindow
);
   import odt_pkg::*;

   odt_mode_t        mode;
   odt_mode_t        next_mode;
   logic [CNT_W-1:0] rfcCnt;
   logic [CNT_W-1:0] next_rfcCnt;
   logic [CNT_W-1:0] xpCnt;
   logic [CNT_W-1:0] next_xpCnt;
   logic [CNT_W-1:0] winCnt;
   logic [CNT_W-1:0] next_winCnt;
   logic             ckePrev;
   logic             next_ckePrev;
   logic             next_rttOn;
   logic             next_asyncMode;
   logic             next_transWindow;
   logic [ODTL_W-1:0] odtLat;
   logic [ODTL_W-1:0] anpdCyc;
   logic [4:0]       syncTap;
   logic             syncOdt;
   logic             asyncOdt;
   logic             ckeFell;
   logic             ckeRose;

   // both turn-on and turn-off latency share one value
   always_comb
   begin
      odtLat = ODTL_W'({2'h0, casWriteLat}) + ODTL_W'({2'h0, additiveLat}) - ODTL_OFFSET; // R14
      // line stage k plus the output flop delays k+1 edges
      if (odtLat < ODTL_OFFSET)
         syncTap = 5'h01;
      else
         syncTap = 5'(odtLat - 6'h01);
      anpdCyc = odtLat + ANPD_EXTRA; // R3
   end

   odt_delay_line u_line
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .odtIn    (odtPin),
      .syncTap  (syncTap),
      .syncOut  (syncOdt),
      .asyncOut (asyncOdt)
   );

   assign ckeFell = ckePrev & ~cke;
   assign ckeRose = ~ckePrev & cke;

   always_comb
   begin
      next_mode    = mode;
      next_ckePrev = cke;
      next_rfcCnt  = (rfcCnt != '0) ? rfcCnt - 1'b1 : rfcCnt;
      next_xpCnt   = (xpCnt != '0) ? xpCnt - 1'b1 : xpCnt;
      next_winCnt  = (winCnt != '0) ? winCnt - 1'b1 : winCnt;
      if (refreshCmd)
         next_rfcCnt = RFC_LOAD;
      case (mode)
         ODT_SYNC:
         begin
            // DLL kept on: power-down never leaves sync mode
            if (ckeFell && !dllOnInPowerdown) // R1
            begin
               if (rfcCnt > 8'h01)
                  next_mode = ODT_ENTRY_WAIT; // R4
               else
                  next_mode = ODT_ASYNC; // R2 R10
            end
         end
         ODT_ENTRY_WAIT:
         begin
            if (cke)
            begin
               next_mode  = ODT_EXIT_WAIT; // R12
               next_xpCnt = XPDLL_LOAD;
            end
            else if (rfcCnt <= 8'h01)
               next_mode = ODT_ASYNC; // R4
         end
         ODT_ASYNC:
         begin
            if (ckeRose)
            begin
               next_mode  = ODT_EXIT_WAIT; // R7
               next_xpCnt = XPDLL_LOAD;
            end
         end
         ODT_EXIT_WAIT:
         begin
            if (ckeFell && !dllOnInPowerdown)
               next_mode = (rfcCnt > 8'h01) ? ODT_ENTRY_WAIT : ODT_ASYNC; // R13
            else if (xpCnt <= 8'h01)
               next_mode = ODT_SYNC; // R11
         end
         default:
            next_mode = ODT_SYNC;
      endcase
      // window flag: tANPD of lookback plus the tail, overlaps merged
      if (!dllOnInPowerdown && (ckeFell || ckeRose))
      begin
         if (ckeRose && (CNT_W'(anpdCyc) + XPDLL_LOAD > next_winCnt))
            next_winCnt = CNT_W'(anpdCyc) + XPDLL_LOAD; // R7 R12
         else if (ckeFell && (CNT_W'(anpdCyc) > next_winCnt))
            next_winCnt = CNT_W'(anpdCyc); // R2 R13
         if (ckeFell && (rfcCnt > next_winCnt))
            next_winCnt = rfcCnt; // R4
      end
   end

   // in-flight sync changes are dropped once async takes over; both
   // paths land inside the mixed min/max bounds, so either is legal
   always_comb
   begin
      next_asyncMode   = (next_mode == ODT_ASYNC) || (next_mode == ODT_EXIT_WAIT);
      next_rttOn       = next_asyncMode ? asyncOdt : syncOdt; // R5 R6 R8 R9 R10 R11
      next_transWindow = (next_winCnt != '0); // R15
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mode        <= ODT_SYNC;
         rfcCnt      <= '0;
         xpCnt       <= '0;
         winCnt      <= '0;
         // cke idles high; a low value here would fake a rising edge
         ckePrev     <= 1'b1;
         rttOn       <= RTT_RESET;
         asyncMode   <= 1'b0;
         transWindow <= 1'b0;
      end
      else
      begin
         mode        <= next_mode;
         rfcCnt      <= next_rfcCnt;
         xpCnt       <= next_xpCnt;
         winCnt      <= next_winCnt;
         ckePrev     <= next_ckePrev;
         rttOn       <= next_rttOn;
         asyncMode   <= next_asyncMode;
         transWindow <= next_transWindow;
      end
   end

   chk_dll_on_sync: assert property ( // R1
      @(posedge clk) disable iff (sys_rst)
      dllOnInPowerdown && mode == ODT_SYNC |=> mode == ODT_SYNC)
      else $error("mode left sync with DLL kept on");

   chk_entry_async: assert property ( // R10
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_SYNC && ckeFell && !dllOnInPowerdown && rfcCnt <= 8'h01
      |=> asyncMode)
      else $error("no async mode after power-down entry");

   chk_refresh_hold: assert property ( // R4
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_SYNC && ckeFell && !dllOnInPowerdown && rfcCnt > 8'h01
      |=> !asyncMode && mode == ODT_ENTRY_WAIT)
      else $error("entry ended while refresh in progress");

   chk_exit_sync: assert property ( // R11
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_EXIT_WAIT && xpCnt <= 8'h01 && !(ckeFell && !dllOnInPowerdown)
      |=> mode == ODT_SYNC && !asyncMode)
      else $error("sync not resumed after exit tail");

   chk_exit_len: assert property ( // R7
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC && ckeRose ##1 (cke && !dllOnInPowerdown)[*6]
      |=> mode == ODT_SYNC)
      else $error("exit window not closed after tXPDLL");

   chk_exit_hold: assert property ( // R11
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC && ckeRose ##1 cke[*6] |-> asyncMode)
      else $error("sync resumed before tXPDLL elapsed");

   chk_async_path: assert property ( // R5 R6
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC ##1 mode == ODT_ASYNC |-> rttOn == $past(odtPin, 2))
      else $error("async termination delay wrong");

   chk_sync_lat: assert property ( // R14
      @(posedge clk) disable iff (sys_rst)
      casWriteLat == 4'h5 && additiveLat == 4'h0 && mode == ODT_SYNC
      ##1 mode == ODT_SYNC |-> rttOn == $past(odtPin, 4))
      else $error("sync termination latency not CWL+AL-2");

   chk_window_flag: assert property ( // R2
      @(posedge clk) disable iff (sys_rst)
      ckeFell && !dllOnInPowerdown && anpdCyc > 6'h01 |=> transWindow [*2])
      else $error("transition window flag missing");

   chk_entry_len: assert property ( // R2 R3
      @(posedge clk) disable iff (sys_rst)
      ckeFell && !dllOnInPowerdown && winCnt == '0 && rfcCnt == '0
      |=> winCnt == {2'h0, $past(anpdCyc)})
      else $error("entry window length not tANPD");

   chk_exit_window: assert property ( // R7
      @(posedge clk) disable iff (sys_rst)
      ckeRose && !dllOnInPowerdown && winCnt == '0
      |=> winCnt == {2'h0, $past(anpdCyc)} + XPDLL_LOAD)
      else $error("exit window length not tANPD plus tXPDLL");

   chk_anpd_value: assert property ( // R3
      @(posedge clk) disable iff (sys_rst)
      {2'h0, casWriteLat} + {2'h0, additiveLat} > 6'h01
      |-> anpdCyc == {2'h0, casWriteLat} + {2'h0, additiveLat} - 6'h01)
      else $error("tANPD not write latency minus one");

   chk_rfc_window: assert property ( // R4
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_SYNC && ckeFell && !dllOnInPowerdown && rfcCnt > 8'h01
      |=> winCnt >= $past(rfcCnt))
      else $error("entry window shorter than refresh remainder");

   chk_rfc_load: assert property ( // R4
      @(posedge clk) disable iff (sys_rst)
      refreshCmd
      |=> rfcCnt == RFC_LOAD)
      else $error("refresh counter not loaded");

   chk_entry_wait_end: assert property ( // R4
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ENTRY_WAIT && !cke && rfcCnt <= 8'h01
      |=> mode == ODT_ASYNC && asyncMode)
      else $error("no async mode after refresh finished");

   chk_dll_on_window: assert property ( // R1
      @(posedge clk) disable iff (sys_rst)
      dllOnInPowerdown && winCnt == '0
      |=> !transWindow)
      else $error("window raised with DLL kept on");

   chk_exit_merge: assert property ( // R12
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC && ckeRose && !dllOnInPowerdown
      |=> transWindow && winCnt >= {2'h0, $past(anpdCyc)} + XPDLL_LOAD)
      else $error("exit window cut short");

   chk_short_high: assert property ( // R13
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_EXIT_WAIT && ckeFell && !dllOnInPowerdown
      |=> transWindow && mode != ODT_SYNC)
      else $error("re-entry during exit tail not merged");

   chk_xp_load: assert property ( // R7
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC && ckeRose
      |=> mode == ODT_EXIT_WAIT && xpCnt == XPDLL_LOAD)
      else $error("exit tail not started");

   chk_async_hold: assert property ( // R10
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_ASYNC && !ckeRose
      |=> mode == ODT_ASYNC && asyncMode)
      else $error("async mode left without cke rising");

   chk_exit_rtt: assert property ( // R8 R9
      @(posedge clk) disable iff (sys_rst)
      mode == ODT_EXIT_WAIT ##1 mode == ODT_EXIT_WAIT
      |-> rttOn == $past(odtPin, 2))
      else $error("exit tail termination delay wrong");

   chk_win_decay: assert property ( // R2 R7
      @(posedge clk) disable iff (sys_rst)
      winCnt > 8'h01
      |=> transWindow)
      else $error("window flag dropped early");
endmodule // odt_powerdown_transition

// *** tb/odt_ctrl_model.sv ***
`timescale 1ns/1ns
module odt_ctrl_model
(
   input  wire logic clk,
   output logic      cke,
   output logic      odtPin,
   output logic      refreshCmd
);
   initial
   begin
      cke        = 1'b1;
      odtPin     = 1'b0;
      refreshCmd = 1'b0;
   end

   // odt only moves outside windows, where termination is deterministic
   task automatic drive(input logic c, input logic o);
      @(posedge clk);
      cke    <= c;
      odtPin <= o;
   endtask

   task automatic refresh();
      @(posedge clk);
      refreshCmd <= 1'b1;
      @(posedge clk);
      refreshCmd <= 1'b0;
   endtask
endmodule // odt_ctrl_model

// *** tb/odt_powerdown_transition_tb_top.sv ***
`timescale 1ns/1ns
module odt_powerdown_transition_tb_top;
   import odt_pkg::*;
   logic             clk    = 1'b0;
   logic             sysRst = 1'b1;
   logic             dllOn  = 1'b0;
   logic [LAT_W-1:0] cwl    = 4'h5;
   logic [LAT_W-1:0] al     = 4'h0;
   wire logic        cke;
   wire logic        odtPin;
   wire logic        refreshCmd;
   wire logic        rttOn;
   wire logic        asyncMode;
   wire logic        transWindow;
   int               errCount = 0;
   int               nTests   = 0;
   int               stA;
   int               lenW;
   int               fallA;

   always #2 clk = ~clk;

   odt_ctrl_model ctrl (.clk(clk), .cke(cke), .odtPin(odtPin), .refreshCmd(refreshCmd));

   odt_powerdown_transition uut (
      .clk(clk), .sys_rst(sysRst), .cke(cke), .odtPin(odtPin), .refreshCmd(refreshCmd),
      .dllOnInPowerdown(dllOn), .casWriteLat(cwl), .additiveLat(al),
      .rttOn(rttOn), .asyncMode(asyncMode), .transWindow(transWindow));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // edges counted from the edge that launched the last drive
   task automatic measure(input int limit);
      stA   = 0;
      lenW  = 0;
      fallA = 0;
      for (int i = 1; i <= limit; i++)
      begin
         @(posedge clk);
         #1;
         if (fallA == 0 && asyncMode === 1'b0)
            fallA = i;
         if (transWindow === 1'b1)
         begin
            lenW++;
            if (stA == 0)
               stA = i;
         end
         else if (lenW > 0)
            break;
      end
   endtask

   task automatic t_sync();
      ctrl.drive(1'b1, 1'b1);
      step(3);
      check("sync on early", rttOn, 0);
      step(1);
      check("sync on", rttOn, 1);
      ctrl.drive(1'b1, 1'b0);
      step(3);
      check("sync off early", rttOn, 1);
      step(1);
      check("sync off", rttOn, 0);
   endtask

   task automatic t_dll_on();
      @(posedge clk);
      dllOn <= 1'b1;
      ctrl.drive(1'b0, 1'b0);
      measure(20);
      check("dll on window", lenW, 0);
      check("dll on mode", asyncMode, 0);
      ctrl.drive(1'b1, 1'b0);
      step(20);
      @(posedge clk);
      dllOn <= 1'b0;
   endtask

   // window lengths follow write latency, one low-latency and one long case
   task automatic t_entry_exit(input logic [3:0] cw, input logic [3:0] a);
      @(posedge clk);
      cwl <= cw;
      al  <= a;
      step(20);
      ctrl.drive(1'b0, 1'b0);
      measure(40);
      check("entry start", stA, 1);
      check("entry len", lenW, cw + a - 1);
      check("entry mode", asyncMode, 1);
      // async answer: 4 ns after the sampling edge
      ctrl.drive(1'b0, 1'b1);
      step(1);
      check("async on early", rttOn, 0);
      step(1);
      check("async on", rttOn, 1);
      ctrl.drive(1'b0, 1'b0);
      step(1);
      check("async off early", rttOn, 1);
      step(1);
      check("async off", rttOn, 0);
      ctrl.drive(1'b1, 1'b0);
      measure(60);
      check("exit start", stA, 1);
      check("exit len", lenW, cw + a - 1 + XPDLL_CYC);
      check("exit mode", fallA, XPDLL_CYC + 1);
      step(10);
   endtask

   task automatic t_short();
      ctrl.drive(1'b0, 1'b0);
      ctrl.drive(1'b1, 1'b0);
      measure(40);
      check("low pulse start", stA, 1);
      check("low pulse len", lenW, 4 + XPDLL_CYC);
      step(10);
      ctrl.drive(1'b0, 1'b0);
      step(20);
      ctrl.drive(1'b1, 1'b0);
      ctrl.drive(1'b0, 1'b0);
      measure(40);
      // exit window opened one edge before the first sample
      check("high pulse start", stA, 1);
      check("high pulse len", lenW, XPDLL_CYC + 3);
      check("high pulse mode", asyncMode, 1);
      ctrl.drive(1'b1, 1'b0);
      step(30);
   endtask

   task automatic t_refresh();
      ctrl.refresh();
      ctrl.drive(1'b0, 1'b0);
      measure(120);
      // refresh lands two cycles before the low sample
      check("refresh start", stA, 1);
      check("refresh len", lenW, RFC_CYC - 1);
      check("refresh mode", asyncMode, 1);
      ctrl.drive(1'b1, 1'b0);
      step(30);
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", errCount, nTests);
      if (errCount == 0 && nTests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #20000;
      errCount++;
      end_of_test();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      sysRst <= 1'b0;
      step(40);
      t_sync();
      t_dll_on();
      t_entry_exit(4'h5, 4'h0);
      t_entry_exit(4'h6, 4'h2);
      @(posedge clk);
      cwl <= 4'h5;
      al  <= 4'h0;
      step(20);
      t_short();
      t_refresh();
      end_of_test();
   end
endmodule // odt_powerdown_transition_tb_top
